// >>> hw/lin_mode_pkg.sv
// Notes on behaviour
// - at battery power-up enter fail-safe with regulator on before other modes.
// - battery supply below 5V inhibits any bus transmission.
// - regulator undervoltage pulls reset low after fall delay, held while it lasts.
// - after regulator recovers, reset stays low a further 4ms.
// - normal mode: transmit low drives bus dominant, high leaves recessive.
// - in fail-safe the transmit pin becomes an output reporting the entry cause.
// - transmit low beyond 27 ms forces the bus driver recessive.
// - after time-out, driver re-enabled only after transmit high beyond 10us.
// - sleep/silent choice uses the real transmit pin level, not the gated one.
// - receive data mirrors bus: high recessive, low dominant.
// - without battery supply the receive output is switched off.
// - enable high means normal mode with transmit and receive paths active.
// - enable falling with transmit high enters silent; regulator stays on.
// - enable falling with transmit low enters sleep; regulator off.
// - transceiver on only in normal; regulator on except in sleep. Receiver is also on in silent once the wake is armed.
// - undervoltage in normal or silent asserts reset and enters fail-safe.
// - silent disconnects termination, weak pull-up only; entry at any bus level.
// - in silent, bus below pre-wake threshold enables receiver and wake timer.
// - fall, dominant beyond filter, rise with transmit high gives wake to fail-safe.
// - after remote wake drive receive and transmit low to the host.
// - enable high moves from silent or after wake directly to normal.
// - fail-safe code: bus wake gives tx low rx low; battery low gives tx high rx low.
// - mode-change requests are ignored while the reset delay holds reset low.
package lin_mode_pkg;

    // timebase: clk_sys at 10 MHz
    localparam int CLK_HZ = 10_000_000;
    localparam int DOM_TIMEOUT_MS = 27;
    localparam int DOM_CYCLES = DOM_TIMEOUT_MS * (CLK_HZ / 1000) + 1; // strictly longer
    localparam int REARM_US = 10;
    localparam int REARM_CYCLES = REARM_US * (CLK_HZ / 1_000_000) + 1;
    localparam int RESET_MS = 4;
    localparam int RESET_CYCLES = RESET_MS * (CLK_HZ / 1000);
    localparam int RES_FALL_CYCLES = 10;  // reset fall delay, plain default
    localparam int BUS_FILTER_CYCLES = 300; // wake dominant filter, plain default
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        FAILSAFE,
        NORMAL,
        SILENT,
        SLEEP
    } mode_t;

    // cause reported while in fail-safe
    typedef enum logic [1:0] {
        SRC_POWERUP,
        SRC_BUSWAKE,
        SRC_BATTLOW
    } fsSource_t;

    // analog monitor flags, already comparator outputs
    typedef struct packed {
        logic batteryPresent;
        logic batteryOk;     // battery_supply above 5V
        logic vccUnder;      // regulator below threshold
        logic prewakeLow;    // bus below prewake_low_threshold
    } monitor_t;

    // pin-side drive outputs
    typedef struct packed {
        logic busDominant;
        logic termOn;
        logic regOn;
        logic rxdOut;
        logic rxdOe;
        logic txdOut;
        logic txdOe;
        logic resetN;
        logic rxOn;
    } pins_t;

endpackage

// >>> hw/lin_fifo.sv
`timescale 1ns/10ps
module lin_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // write side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // read side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("depth must be a power of two of at least two");
    end

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifoState_t;

    fifoState_t s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doWr, doRd;

    assign inReady = (s_q.wr - s_q.rd) != (AW+1)'(DEPTH);
    assign outValid = s_q.wr != s_q.rd;
    assign outData = mem[s_q.rd[AW-1:0]];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // pointer advance
    always_comb
    begin
        s_d = s_q;
        if (doWr)
            s_d.wr = s_q.wr + 1'b1;
        if (doRd)
            s_d.rd = s_q.rd + 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
        if (doWr)
            mem[s_q.wr[AW-1:0]] <= inData;
    end
endmodule

// >>> hw/lin_transceiver_mode_control.sv
`timescale 1ns/10ps
module lin_transceiver_mode_control #(
    parameter int DOM_LIMIT = lin_mode_pkg::DOM_CYCLES,
    parameter int RESET_LIMIT = lin_mode_pkg::RESET_CYCLES,
    parameter int REARM_LIMIT = lin_mode_pkg::REARM_CYCLES,
    parameter int FILTER_LIMIT = lin_mode_pkg::BUS_FILTER_CYCLES,
    parameter int FALL_LIMIT = lin_mode_pkg::RES_FALL_CYCLES
) (
    // clock and reset (rst models battery power-on)
    input wire logic clk_sys,
    input wire logic rst,
    // host pins
    input wire logic enable,
    input wire logic txdIn,
    // bus receiver level, high is recessive
    input wire logic busLevel,
    // analog monitors
    input wire lin_mode_pkg::monitor_t monitors,
    // pin drives
    output lin_mode_pkg::pins_t pins,
    output lin_mode_pkg::mode_t mode
);
    import lin_mode_pkg::*;

    localparam int CW = $clog2(DOM_LIMIT + 1);

    // every counter shares the width sized from the dominant limit
    if (DOM_LIMIT < 2 || RESET_LIMIT < 1 || REARM_LIMIT < 1 || FILTER_LIMIT < 1
        || FALL_LIMIT < 1 || RESET_LIMIT > DOM_LIMIT || FILTER_LIMIT > DOM_LIMIT
        || REARM_LIMIT > DOM_LIMIT || FALL_LIMIT > DOM_LIMIT)
    begin
        $error("timing limits out of range");
    end

    // synchroniser stages: first stage read only by second
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
    } sync_t;

    typedef struct packed {
        mode_t mode;
        fsSource_t src;
        logic enPrev;
        logic domOff;         // dominant time-out tripped
        logic [CW-1:0] domCnt;
        logic [CW-1:0] rearmCnt;
        logic [CW-1:0] resCnt;
        logic resHold;        // reset held low
        logic [CW-1:0] fallCnt;
        logic wakeArmed;      // saw fall below prewake
        logic [CW-1:0] wakeCnt;
        pins_t pins;
    } state_t;

    state_t s_q, s_d;
    sync_t y_q;
    logic enS, txS, busS, battOk, battPres, vccLow, preS;
    logic enFall, wantTx, bufOut, bufValid;

    // two flops on every pin and monitor input
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            y_q <= '{s1: 7'h7E, s2: 7'h7E};
        else
        begin
            y_q.s1 <= {enable, txdIn, busLevel, monitors.batteryOk,
                       monitors.batteryPresent, monitors.vccUnder, monitors.prewakeLow};
            y_q.s2 <= y_q.s1;
        end
    end
    // prewake comparator is asynchronous too, so it rides the same two stages
    assign {enS, txS, busS, battOk, battPres, vccLow, preS} = y_q.s2;

    // bus drive request passes a small buffer so the driver path is registered
    lin_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) txBuf (
        .clk_sys(clk_sys),
        .rst(rst),
        .inValid(1'b1),
        .inReady(),
        .inData(wantTx),
        .outValid(bufValid),
        .outReady(1'b1),
        .outData(bufOut)
    );

    assign enFall = s_q.enPrev && !enS;
    // transmit allowed only in normal with good battery and no time-out
    assign wantTx = (s_q.mode == NORMAL) && battOk && !s_q.domOff && !txS;

    always_comb
    begin
        s_d = s_q;
        s_d.enPrev = enS;

        // dominant time-out and re-arm
        if (!txS)
        begin
            s_d.rearmCnt = '0;
            if (s_q.domCnt >= CW'(DOM_LIMIT - 1))
                s_d.domOff = 1'b1;
            else
                s_d.domCnt = s_q.domCnt + 1'b1;
        end
        else
        begin
            s_d.domCnt = '0;
            if (s_q.rearmCnt >= CW'(REARM_LIMIT - 1))
                s_d.domOff = 1'b0;
            else
                s_d.rearmCnt = s_q.rearmCnt + 1'b1;
        end

        // reset output: fall delay then hold for the reset time after recovery
        if (vccLow)
        begin
            s_d.resCnt = '0;
            if (s_q.fallCnt >= CW'(FALL_LIMIT - 1))
                s_d.resHold = 1'b1;
            else
                s_d.fallCnt = s_q.fallCnt + 1'b1;
        end
        else
        begin
            s_d.fallCnt = '0;
            if (s_q.resHold)
            begin
                if (s_q.resCnt >= CW'(RESET_LIMIT - 1))
                    s_d.resHold = 1'b0;
                else
                    s_d.resCnt = s_q.resCnt + 1'b1;
            end
        end

        // mode machine
        unique case (s_q.mode)
            FAILSAFE:
            begin
                if (!battOk)
                    s_d.src = SRC_BATTLOW;
                if (enS && !s_q.resHold)
                begin
                    s_d.mode = NORMAL;
                end
            end
            NORMAL:
            begin
                if (s_q.resHold)
                begin
                    s_d.mode = FAILSAFE;
                    s_d.src = SRC_POWERUP;
                end
                else if (enFall)
                    s_d.mode = txS ? SILENT : SLEEP;
            end
            SILENT:
            begin
                if (s_q.resHold)
                begin
                    s_d.mode = FAILSAFE;
                    s_d.src = SRC_POWERUP;
                    s_d.wakeArmed = 1'b0;
                end
                else if (enS)
                begin
                    s_d.mode = NORMAL;
                    s_d.wakeArmed = 1'b0;
                end
                else if (s_q.wakeArmed)
                begin
                    if (!busS)
                    begin
                        if (s_q.wakeCnt < CW'(FILTER_LIMIT))
                            s_d.wakeCnt = s_q.wakeCnt + 1'b1;
                    end
                    else
                    begin
                        s_d.wakeArmed = 1'b0;
                        if (s_q.wakeCnt >= CW'(FILTER_LIMIT) && txS)
                        begin
                            s_d.mode = FAILSAFE;
                            s_d.src = SRC_BUSWAKE;
                        end
                    end
                end
                else if (preS && !busS)
                begin
                    s_d.wakeArmed = 1'b1;
                    s_d.wakeCnt = '0;
                end
            end
            SLEEP:
            begin
                // wake from sleep lies outside this block; enable still leaves it
                if (enS && !s_q.resHold)
                    s_d.mode = FAILSAFE;
            end
        endcase

        // battery loss forces fail-safe
        if (!battPres)
        begin
            s_d.mode = FAILSAFE;
            s_d.src = SRC_BATTLOW;
        end

        // pin drives from next mode
        s_d.pins.busDominant = bufValid && bufOut;
        s_d.pins.termOn = s_d.mode != SILENT && s_d.mode != SLEEP;
        s_d.pins.regOn = s_d.mode != SLEEP;
        s_d.pins.resetN = !s_d.resHold;
        s_d.pins.rxOn = s_d.mode == NORMAL || s_d.wakeArmed;
        s_d.pins.rxdOe = battPres;
        s_d.pins.txdOe = s_d.mode == FAILSAFE;
        s_d.pins.txdOut = 1'b1;
        unique case (s_d.mode)
            NORMAL:
                s_d.pins.rxdOut = busS;
            FAILSAFE:
            begin
                s_d.pins.rxdOut = 1'b0;
                s_d.pins.txdOut = s_d.src != SRC_BUSWAKE;
            end
            SILENT:
                s_d.pins.rxdOut = 1'b1;
            SLEEP:
                s_d.pins.rxdOut = 1'b0;
        endcase
    end

    // state register; power-on lands in fail-safe with reset held
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.mode <= FAILSAFE;
            s_q.resHold <= 1'b1;
            s_q.pins <= '{busDominant: 1'b0, termOn: 1'b1, regOn: 1'b1, rxdOut: 1'b0,
                          rxdOe: 1'b1, txdOut: 1'b1, txdOe: 1'b1, resetN: 1'b0,
                          rxOn: 1'b0};
        end
        else
            s_q <= s_d;
    end

    assign pins = s_q.pins;
    assign mode = s_q.mode;
endmodule

// >>> bench/lin_mode_monitor.sv
`timescale 1ns/10ps
module lin_mode_monitor #(
    parameter int DOM_LIMIT = lin_mode_pkg::DOM_CYCLES,
    parameter int RESET_LIMIT = lin_mode_pkg::RESET_CYCLES,
    parameter int FALL_LIMIT = lin_mode_pkg::RES_FALL_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // block inputs
    input wire logic enable,
    input wire logic txdIn,
    input wire logic busLevel,
    input wire lin_mode_pkg::monitor_t monitors,
    // block outputs
    input wire lin_mode_pkg::pins_t pins,
    input wire lin_mode_pkg::mode_t mode
);
    import lin_mode_pkg::*;
    localparam int FALL_MAX = FALL_LIMIT + 5;
    int lowCnt;
    int okCnt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // run lengths of txd low and vcc good; saturate so they never wrap
    always_ff @(posedge clk_sys)
    begin
        if (rst || txdIn)
            lowCnt <= 0;
        else if (lowCnt < DOM_LIMIT + 8)
            lowCnt <= lowCnt + 1;
        if (rst || monitors.vccUnder)
            okCnt <= 0;
        else if (okCnt < RESET_LIMIT + 8)
            okCnt <= okCnt + 1;
    end

    // enable drops out of normal, txd high or low
    sequence s_dropHigh;
        mode == NORMAL && $fell(enable) && txdIn;
    endsequence
    sequence s_dropLow;
        mode == NORMAL && $fell(enable) && !txdIn;
    endsequence
    // bus steady long enough to cross the synchroniser
    sequence s_busSteady;
        (mode == NORMAL && $stable(busLevel)) [*6];
    endsequence
    // silent left for fail-safe with supplies good
    sequence s_wake;
        $past(mode) == SILENT && mode == FAILSAFE && monitors.batteryOk && !monitors.vccUnder;
    endsequence

    a_silent_entry: assert property (s_dropHigh |-> ##[1:4] mode == SILENT)
        else $error("silent mode not entered");
    a_sleep_entry: assert property (s_dropLow |-> ##[1:4] mode == SLEEP)
        else $error("sleep mode not entered");
    a_tx_gated: assert property (mode != NORMAL [*8] |-> !pins.busDominant)
        else $error("bus driven outside normal");
    a_battery_gate: assert property (!monitors.batteryOk [*8] |-> !pins.busDominant)
        else $error("bus driven on low battery");
    a_dom_timeout: assert property (lowCnt >= DOM_LIMIT + 8 |-> !pins.busDominant)
        else $error("dominant time-out missed");
    a_rxd_mirror: assert property (s_busSteady |-> pins.rxdOut == busLevel)
        else $error("rxd does not follow bus");
    a_wake_code: assert property (s_wake |-> ##[0:2] (pins.txdOe && !pins.txdOut && !pins.rxdOut))
        else $error("wake code wrong");
    a_uv_reset: assert property ($rose(monitors.vccUnder) |-> ##[1:FALL_MAX] !pins.resetN)
        else $error("reset not pulled low");
    a_reset_delay: assert property ($rose(pins.resetN) && okCnt < RESET_LIMIT + 8 |-> okCnt >= RESET_LIMIT)
        else $error("reset released early");
    a_delay_mode: assert property (mode == FAILSAFE && !pins.resetN |=> mode == FAILSAFE || pins.resetN)
        else $error("mode changed during reset delay");
endmodule

bind lin_transceiver_mode_control lin_mode_monitor #(
    .DOM_LIMIT(DOM_LIMIT), .RESET_LIMIT(RESET_LIMIT), .FALL_LIMIT(FALL_LIMIT)
) i_mon (
    .clk_sys(clk_sys), .rst(rst), .enable(enable), .txdIn(txdIn), .busLevel(busLevel),
    .monitors(monitors), .pins(pins), .mode(mode)
);

// >>> bench/lin_host_bus_model.sv
`timescale 1ns/10ps
module lin_host_bus_model (
    // device drives
    input wire lin_mode_pkg::pins_t pins,
    // host and other node requests
    input wire logic hostTxd,
    input wire logic otherDom,
    // resolved wire levels
    output logic txdIn,
    output logic busLevel
);
    import lin_mode_pkg::*;
    // shared txd pin: device owns it while its enable is up
    assign txdIn = pins.txdOe ? pins.txdOut : hostTxd;
    // wired-and bus with pull-up; any node can pull it dominant
    assign busLevel = !(pins.busDominant || otherDom);
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import lin_mode_pkg::*;
    localparam int DOM = 200;
    localparam int RST = 50;
    localparam int FLT = 20;
    logic clk_sys, rst, enable, hostTxd, otherDom, txdIn, busLevel;
    monitor_t monitors;
    pins_t pins;
    mode_t mode;
    int miscompares = 0;
    int testsRun = 0;

    // short counts keep the run brief
    lin_transceiver_mode_control #(.DOM_LIMIT(DOM), .RESET_LIMIT(RST), .FILTER_LIMIT(FLT))
    i_dut (.clk_sys(clk_sys), .rst(rst), .enable(enable), .txdIn(txdIn),
        .busLevel(busLevel), .monitors(monitors), .pins(pins), .mode(mode));
    lin_host_bus_model i_bus (.pins(pins), .hostTxd(hostTxd), .otherDom(otherDom),
        .txdIn(txdIn), .busLevel(busLevel));

    // clock
    initial
    begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // inputs move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chkBit(input string what, input logic exp, input logic got);
        testsRun++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chkMode(input mode_t exp);
        testsRun++;
        if (mode !== exp)
        begin
            miscompares++;
            $display("wrong value mode expected %s seen %s", exp.name(), mode.name());
        end
    endtask

    // bounded wait, since mode lags the inputs through the synchroniser
    task automatic waitMode(input mode_t m);
        for (int i = 0; i < 20 && mode !== m; i++)
            step(1);
        chkMode(m);
    endtask

    task automatic endOfTest;
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tReset;
        chkMode(FAILSAFE);
        chkBit("regOn", 1'h1, pins.regOn);
        enable = 1'h1;
        step(RST - 10);
        chkMode(FAILSAFE);
        chkBit("resetN", 1'h0, pins.resetN);
        waitMode(NORMAL);
        $display("reset done");
    endtask

    task automatic tNormal;
        hostTxd = 1'h0;
        step(12);
        chkBit("busDominant", 1'h1, pins.busDominant);
        chkBit("rxdOut", 1'h0, pins.rxdOut);
        chkBit("rxOn", 1'h1, pins.rxOn);
        hostTxd = 1'h1;
        step(12);
        chkBit("busDominant", 1'h0, pins.busDominant);
        chkBit("rxdOut", 1'h1, pins.rxdOut);
        $display("normal done");
    endtask

    // a high shorter than the rearm span must not rearm the driver
    task automatic tTimeout;
        hostTxd = 1'h0;
        step(DOM - 10);
        chkBit("busDominant", 1'h1, pins.busDominant);
        step(22);
        chkBit("busDominant", 1'h0, pins.busDominant);
        hostTxd = 1'h1;
        step(3);
        hostTxd = 1'h0;
        step(12);
        chkBit("busDominant", 1'h0, pins.busDominant);
        hostTxd = 1'h1;
        step(REARM_CYCLES + 8);
        hostTxd = 1'h0;
        step(12);
        chkBit("busDominant", 1'h1, pins.busDominant);
        hostTxd = 1'h1;
        monitors.batteryOk = 1'h0;
        step(4);
        hostTxd = 1'h0;
        step(12);
        chkBit("busDominant", 1'h0, pins.busDominant);
        hostTxd = 1'h1;
        monitors.batteryOk = 1'h1;
        waitMode(NORMAL);
        $display("timeout done");
    endtask

    // a dominant pulse shorter than the filter must not wake
    task automatic tSilent;
        enable = 1'h0;
        waitMode(SILENT);
        chkBit("termOn", 1'h0, pins.termOn);
        chkBit("rxOn", 1'h0, pins.rxOn);
        chkBit("regOn", 1'h1, pins.regOn);
        otherDom = 1'h1;
        monitors.prewakeLow = 1'h1;
        step(5);
        otherDom = 1'h0;
        step(12);
        chkMode(SILENT);
        // a long dominant while txd is low must not wake either
        hostTxd = 1'h0;
        otherDom = 1'h1;
        step(FLT + 10);
        chkBit("rxOn", 1'h1, pins.rxOn);
        otherDom = 1'h0;
        step(12);
        chkMode(SILENT);
        hostTxd = 1'h1;
        otherDom = 1'h1;
        step(FLT + 10);
        otherDom = 1'h0;
        monitors.prewakeLow = 1'h0;
        waitMode(FAILSAFE);
        step(2);
        chkBit("txdOut", 1'h0, pins.txdOut);
        chkBit("txdOe", 1'h1, pins.txdOe);
        chkBit("rxdOut", 1'h0, pins.rxdOut);
        chkBit("termOn", 1'h1, pins.termOn);
        enable = 1'h1;
        waitMode(NORMAL);
        $display("silent done");
    endtask

    task automatic tUnder;
        monitors.vccUnder = 1'h1;
        step(4);
        chkBit("resetN", 1'h1, pins.resetN);
        step(RES_FALL_CYCLES + 4);
        chkBit("resetN", 1'h0, pins.resetN);
        chkMode(FAILSAFE);
        chkBit("txdOut", 1'h1, pins.txdOut);
        chkBit("rxdOut", 1'h0, pins.rxdOut);
        step(20);
        chkBit("resetN", 1'h0, pins.resetN);
        monitors.vccUnder = 1'h0;
        step(RST - 4);
        chkBit("resetN", 1'h0, pins.resetN);
        step(10);
        chkBit("resetN", 1'h1, pins.resetN);
        waitMode(NORMAL);
        $display("undervoltage done");
    endtask

    // txd stays low past the time-out, so the pin level picks sleep
    task automatic tSleep;
        hostTxd = 1'h0;
        step(DOM + 12);
        enable = 1'h0;
        waitMode(SLEEP);
        step(2);
        chkBit("regOn", 1'h0, pins.regOn);
        hostTxd = 1'h1;
        enable = 1'h1;
        step(12);
        chkBit("regOn", 1'h1, pins.regOn);
        monitors.batteryPresent = 1'h0;
        step(8);
        chkBit("rxdOe", 1'h0, pins.rxdOe);
        chkBit("txdOe", 1'h1, pins.txdOe);
        chkBit("txdOut", 1'h1, pins.txdOut);
        chkBit("rxdOut", 1'h0, pins.rxdOut);
        $display("sleep done");
    endtask

    // main sequence
    initial
    begin
        rst = 1'h1;
        enable = 1'h0;
        hostTxd = 1'h1;
        otherDom = 1'h0;
        monitors = 4'hC;
        step(2);
        rst = 1'h0;
        tReset();
        tNormal();
        tTimeout();
        tSilent();
        tUnder();
        tSleep();
        endOfTest();
    end

    // watchdog; the tests need well under 2000 cycles
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        endOfTest();
    end
endmodule
